// ---- pkg/ctu_pkg.sv ----
// Constants of the charge-time control block.
// Assumes a byte-wide plain register port.
package ctu_pkg;

    // Register width and address width of the plain register port.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // Register offsets, one word each.
    localparam logic [2:0] OFF_MAIN_CONTROL  = 3'h0;
    localparam logic [2:0] OFF_CURRENT_CFG   = 3'h1;
    localparam logic [2:0] OFF_SECOND_EDGE   = 3'h2;
    localparam logic [2:0] OFF_FIRST_EDGE    = 3'h3;
    localparam logic [2:0] OFF_FLAG_REG      = 3'h4;
    localparam logic [2:0] OFF_ENABLE_REG    = 3'h5;
    localparam logic [2:0] OFF_LIVE_STATUS   = 3'h6;

    // Field positions in the main control register.
    localparam int BIT_UNIT_ENABLE     = 7;
    localparam int BIT_DELAY_MODE      = 4;
    localparam int BIT_EDGES_ARMED     = 3;
    localparam int BIT_EDGE_ORDER      = 2;
    localparam int BIT_DISCHARGE       = 1;
    localparam int BIT_CONV_TRIGGER    = 0;

    // Field positions in the current configuration register.
    localparam int RANGE_LO = 0;
    localparam int RANGE_HI = 1;
    localparam int TRIM_LO  = 2;
    localparam int TRIM_HI  = 7;

    // Field positions shared by both edge configuration registers.
    localparam int BIT_POLARITY = 6;
    localparam int SEL_LO       = 2;
    localparam int SEL_HI       = 5;

    // Edge status bits in the first edge configuration register.
    localparam int BIT_FIRST_SEEN  = 0;
    localparam int BIT_SECOND_SEEN = 1;

    // Interrupt flag and enable position in the peripheral registers.
    localparam int BIT_UNIT_IRQ = 3;

    // Live status register fields.
    localparam int BIT_LIVE_SOURCE_ON = 0;
    localparam int BIT_LIVE_PULSE     = 1;

    // Reset values of all software registers.
    localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_CURRENT_CFG  = 8'h00;
    localparam logic [7:0] RST_EDGE_CFG     = 8'h00;
    localparam logic       RST_BIT          = 1'b0;

    // Range code that leaves the current source unpowered.
    localparam logic [1:0] RANGE_OFF = 2'h0;

    // Edge source codes for the four-bit source select fields.
    localparam logic [3:0] SRC_EDGE_PIN_ONE  = 4'h0;
    localparam logic [3:0] SRC_EDGE_PIN_TWO  = 4'h1;
    localparam logic [3:0] SRC_CAPTURE_ONE   = 4'h2;
    localparam logic [3:0] SRC_CAPTURE_TWO   = 4'h3;

endpackage

// ---- verif/ctu_chk.sv ----
// Checker for the charge-time unit, watching only its top-level ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module ctu_chk (
    // Clock and reset.
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    // Register port.
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Analog control and events.
    input wire logic       current_on_o,
    input wire logic [1:0] current_range_o,
    input wire logic [5:0] current_trim_o,
    input wire logic       discharge_o,
    input wire logic       comparator_ref_en_o,
    input wire logic       adc_start_o,
    input wire logic       irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // Writes to the two control registers, the first step of half the checks.
    sequence s_cfg_wr;
        wr_i && addr_i == ctu_pkg::OFF_CURRENT_CFG;
    endsequence
    sequence s_main_wr;
        wr_i && addr_i == ctu_pkg::OFF_MAIN_CONTROL;
    endsequence
    property p_cfg_out;
        s_cfg_wr |=> {current_trim_o, current_range_o} == $past(wdata_i);
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("current fields differ from write");
    property p_cfg_read;
        rd_i && addr_i == ctu_pkg::OFF_CURRENT_CFG |=> rdata_o == $past({current_trim_o, current_range_o});
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("current config read wrong");
    property p_unit_off;
        s_main_wr ##0 !wdata_i[7] |-> ##[1:2] !current_on_o;
    endproperty
    a_unit_off: assert property (p_unit_off) else $error("source on with unit off");
    property p_irq_mask;
        wr_i && addr_i == ctu_pkg::OFF_ENABLE_REG && !wdata_i[3] |=> ##1 !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("request while masked");
    property p_adc_pulse;
        adc_start_o |=> !adc_start_o;
    endproperty
    a_adc_pulse: assert property (p_adc_pulse) else $error("conversion start too long");
    property p_discharge;
        s_main_wr ##0 wdata_i[1] |-> ##[1:2] discharge_o;
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge not driven");
    property p_ref_en;
        s_main_wr ##0 wdata_i[7] && wdata_i[4] |-> ##[1:2] comparator_ref_en_o;
    endproperty
    a_ref_en: assert property (p_ref_en) else $error("reference not enabled");
    property p_live_read;
        rd_i && addr_i == ctu_pkg::OFF_LIVE_STATUS |=> rdata_o[0] == $past(current_on_o);
    endproperty
    a_live_read: assert property (p_live_read) else $error("live status read wrong");
endmodule

bind ctu_charge_time_unit ctu_chk ctu_chk_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .current_on_o(current_on_o),
    .current_range_o(current_range_o), .current_trim_o(current_trim_o), .discharge_o(discharge_o),
    .comparator_ref_en_o(comparator_ref_en_o), .adc_start_o(adc_start_o), .irq_o(irq_o)
);

// ---- verif/ctu_edge_model.sv ----
// Model of the edge sources and the comparator.
// Assumes the bench calls strike to pulse one line.
`timescale 1ns/1ns
module ctu_edge_model (
    // Clock of the unit, used only to pace the lines.
    input  wire logic       clock_i,
    // Lines: pin one, pin two, capture one, capture two, comparator.
    output logic      [4:0] line_o
);
    // Lines rest low, so falling polarity sees nothing.
    initial line_o = 5'h00;

    // Four cycles high outlast the synchroniser.
    task automatic strike(input int n);
        @(posedge clock_i);
        line_o[n] <= 1'b1;
        repeat (4) @(posedge clock_i);
        line_o[n] <= 1'b0;
    endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the charge-time unit, driving its register port.
// Assumes the edge model supplies every edge line and the comparator.
`timescale 1ns/1ns
module tb;
    logic       clock_i, reset_n_i, wr_i, rd_i, cur_on, disch, ref_en, pulse, adc, irq;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata;
    logic [1:0] range;
    logic [5:0] trim;
    logic [4:0] line;
    logic [3:0] s;
    int         fail_count, checks_done, adc_n, n;

    ctu_charge_time_unit ctu_charge_time_unit_i (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .edge_pin_one_i(line[0]),
        .edge_pin_two_i(line[1]), .capture_one_trigger_i(line[2]), .capture_two_trigger_i(line[3]),
        .comparator_out_i(line[4]), .current_on_o(cur_on), .current_range_o(range),
        .current_trim_o(trim), .discharge_o(disch), .comparator_ref_en_o(ref_en),
        .pulse_o(pulse), .adc_start_o(adc), .irq_o(irq)
    );
    ctu_edge_model ctu_edge_model_i (
        .clock_i(clock_i),
        .line_o(line)
    );

    // Free-running 100 MHz clock.
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Count conversion starts.
    always @(posedge clock_i)
        if (adc === 1'b1) adc_n <= adc_n + 1;

    task final_report;
        $display("mismatches %0d, comparisons %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe.
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // Data stand one cycle after the strobe.
    task rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask

    // Bounded wait; a hang ends the run.
    task wait_on(input logic v);
        int k;
        for (k = 0; k < 40 && cur_on !== v; k++) tick(1);
        chk({7'h00, cur_on}, {7'h00, v});
        if (k == 40) final_report;
    endtask

    initial
    begin
        reset_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 3'h0; wdata_i = 8'h00;
        fail_count = 0; checks_done = 0; adc_n = 0;
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        // All words read zero after reset.
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
        for (int r = 1; r < 4; r++)
        begin
            wr(ctu_pkg::OFF_CURRENT_CFG, 8'hA8 | r[7:0]);
            rd(ctu_pkg::OFF_CURRENT_CFG, 8'hA8 | r[7:0]);
            chk({6'h00, range}, r[7:0]);
            chk({2'h0, trim}, 8'h2A);
        end
        wr(ctu_pkg::OFF_SECOND_EDGE, 8'hFF);
        rd(ctu_pkg::OFF_SECOND_EDGE, 8'h7C);
        // Software start and stop sets the flag.
        wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h80);
        wr(ctu_pkg::OFF_FIRST_EDGE, 8'h01);
        wait_on(1'b1);
        wr(ctu_pkg::OFF_FIRST_EDGE, 8'h00);
        wait_on(1'b0);
        rd(ctu_pkg::OFF_FLAG_REG, 8'h08);
        chk({7'h00, irq}, 8'h00);
        wr(ctu_pkg::OFF_ENABLE_REG, 8'h08);
        tick(2);
        chk({7'h00, irq}, 8'h01);
        wr(ctu_pkg::OFF_FLAG_REG, 8'h00);
        wr(ctu_pkg::OFF_ENABLE_REG, 8'h00);
        // Every source code, one conversion each.
        for (int c = 0; c < 4; c++)
        begin
            s = c[3:0];
            wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h00);
            wr(ctu_pkg::OFF_SECOND_EDGE, {2'h1, s ^ 4'h1, 2'h0});
            wr(ctu_pkg::OFF_FIRST_EDGE, {2'h1, s, 2'h0});
            wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h89);
            n = adc_n;
            ctu_edge_model_i.strike(c);
            wait_on(1'b1);
            rd(ctu_pkg::OFF_FIRST_EDGE, {2'h1, s, 2'h1});
            ctu_edge_model_i.strike(c ^ 1);
            wait_on(1'b0);
            rd(ctu_pkg::OFF_FIRST_EDGE, {2'h1, s, 2'h3});
            chk(8'(adc_n - n), 8'h01);
            rd(ctu_pkg::OFF_FLAG_REG, 8'h08);
            wr(ctu_pkg::OFF_FLAG_REG, 8'h00);
        end
        // Unarmed edges are ignored.
        wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h80);
        wr(ctu_pkg::OFF_FIRST_EDGE, 8'h48);
        ctu_edge_model_i.strike(2);
        tick(6);
        rd(ctu_pkg::OFF_FIRST_EDGE, 8'h48);
        // With ordering, a second edge before the first is ignored.
        wr(ctu_pkg::OFF_SECOND_EDGE, 8'h4C);
        wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h8C);
        n = adc_n;
        ctu_edge_model_i.strike(3);
        tick(6);
        rd(ctu_pkg::OFF_FIRST_EDGE, 8'h48);
        ctu_edge_model_i.strike(2);
        wait_on(1'b1);
        ctu_edge_model_i.strike(3);
        wait_on(1'b0);
        rd(ctu_pkg::OFF_FIRST_EDGE, 8'h4B);
        chk(8'(adc_n - n), 8'h00);
        // Discharge follows its bit.
        wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h02);
        tick(2);
        chk({7'h00, disch}, 8'h01);
        wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h00);
        tick(2);
        chk({7'h00, disch}, 8'h00);
        // Delay mode pulse ended by the comparator.
        wr(ctu_pkg::OFF_FIRST_EDGE, 8'h48);
        wr(ctu_pkg::OFF_MAIN_CONTROL, 8'h90);
        tick(2);
        chk({7'h00, ref_en}, 8'h01);
        wr(ctu_pkg::OFF_FIRST_EDGE, 8'h49);
        wait_on(1'b1);
        tick(1);
        chk({7'h00, pulse}, 8'h01);
        rd(ctu_pkg::OFF_LIVE_STATUS, 8'h03);
        ctu_edge_model_i.strike(4);
        wait_on(1'b0);
        tick(1);
        chk({7'h00, pulse}, 8'h00);
        rd(ctu_pkg::OFF_FIRST_EDGE, 8'h4B);
        final_report;
    end
endmodule

// ---- verilog/ctu_charge_time_unit.sv ----
// Control logic of the charge-time measurement unit.
// Registers, edges, source switching, trigger and interrupt.
// Assumes pins and comparator are asynchronous and the
// capture-compare triggers share this clock.
//
// Behaviour
// R1: Source on-then-off sets the interrupt flag.
// R2: Interrupt request needs flag and enable both.
// R3: With ordering, second edge needs first seen.
// R4: Software reads both status bits without ordering.
// R5: Two-bit range and six-bit trim fields.
// R6: Four-bit source select per edge, bits 5:2.
// R7: Polarity at bit six, falling by default.
// R8: Edge order enable at bit two, off.
// R9: Mode bit four, measurement by default.
// R10: Trigger bit zero starts conversion on second edge.
// R11: Discharge bit drains the circuit while set.
// R12: Unit enable bit seven switches unit.
// R13: Software clears both status bits together.
// R14: Edges armed bit three arms both inputs.
// R15: Writing first status one turns source on.
// R16: Capture-compare triggers selectable as edge sources.
// R17: Delay mode ends pulse on comparator trip.
// R18: Range selects three ranges, trim adjusts each.
// R19: Software follows the recommended setup order.
// R20: Qualified edges set status; source on between.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module ctu_charge_time_unit (
    // Clock and reset.
    input  wire logic                        clock_i,
    input  wire logic                        reset_n_i,
    // Register port.
    input  wire logic [ctu_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [ctu_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [ctu_pkg::DATA_W-1:0]  rdata_o,
    // Edge sources.
    input  wire logic                        edge_pin_one_i,
    input  wire logic                        edge_pin_two_i,
    input  wire logic                        capture_one_trigger_i,
    input  wire logic                        capture_two_trigger_i,
    // Second comparator output, used in delay mode.
    input  wire logic                        comparator_out_i,
    // Analog control.
    output logic                             current_on_o,
    output logic      [1:0]                  current_range_o,
    output logic      [5:0]                  current_trim_o,
    output logic                             discharge_o,
    output logic                             comparator_ref_en_o,
    output logic                             pulse_o,
    // Conversion start and interrupt request.
    output logic                             adc_start_o,
    output logic                             irq_o
);

    // Software registers.
    logic [7:0] main_control_reg;          // Enable, mode, arm, order, discharge, trigger.
    logic [7:0] current_config_reg;        // Range and trim.
    logic [6:2] second_edge_config_reg;    // Polarity and source select of the second edge.
    logic [6:2] first_edge_config_reg;     // Polarity and source select of the first edge.
    logic       first_edge_seen;           // First edge status bit.
    logic       second_edge_seen;          // Second edge status bit.
    logic       peripheral_flag;           // Interrupt flag of this unit.
    logic       peripheral_enable;         // Interrupt enable of this unit.

    // Next values of the hardware-updated bits.
    logic       next_first_edge_seen;
    logic       next_second_edge_seen;
    logic       next_peripheral_flag;

    // Synchronised external levels.
    logic [1:0] pin_sync;                  // Both edge pins after two flops.
    logic       comparator_sync;           // Comparator after two flops.

    // Write decode, one wire per writable register.
    wire wr_main    = wr_i && (addr_i == ctu_pkg::OFF_MAIN_CONTROL);
    wire wr_current = wr_i && (addr_i == ctu_pkg::OFF_CURRENT_CFG);
    wire wr_second  = wr_i && (addr_i == ctu_pkg::OFF_SECOND_EDGE);
    wire wr_first   = wr_i && (addr_i == ctu_pkg::OFF_FIRST_EDGE);
    wire wr_flag    = wr_i && (addr_i == ctu_pkg::OFF_FLAG_REG);
    wire wr_enable  = wr_i && (addr_i == ctu_pkg::OFF_ENABLE_REG);

    // Named control fields.
    wire       unit_enable               = main_control_reg[ctu_pkg::BIT_UNIT_ENABLE];    // [R12]
    wire       delay_mode_sel            = main_control_reg[ctu_pkg::BIT_DELAY_MODE];     // [R9]
    wire       edges_armed               = main_control_reg[ctu_pkg::BIT_EDGES_ARMED];    // [R14]
    wire       edge_order_enable         = main_control_reg[ctu_pkg::BIT_EDGE_ORDER];     // [R8]
    wire       discharge_enable          = main_control_reg[ctu_pkg::BIT_DISCHARGE];      // [R11]
    wire       conversion_trigger_enable = main_control_reg[ctu_pkg::BIT_CONV_TRIGGER];   // [R10]
    wire [1:0] current_range_sel         = current_config_reg[ctu_pkg::RANGE_HI:ctu_pkg::RANGE_LO];
    wire [5:0] current_trim              = current_config_reg[ctu_pkg::TRIM_HI:ctu_pkg::TRIM_LO];
    wire [3:0] first_edge_source_sel     = first_edge_config_reg[ctu_pkg::SEL_HI:ctu_pkg::SEL_LO];
    wire [3:0] second_edge_source_sel    = second_edge_config_reg[ctu_pkg::SEL_HI:ctu_pkg::SEL_LO];
    wire       first_edge_polarity       = first_edge_config_reg[ctu_pkg::BIT_POLARITY];
    wire       second_edge_polarity      = second_edge_config_reg[ctu_pkg::BIT_POLARITY];

    // Edge pulses from the detectors.
    logic first_edge_pulse;
    logic second_edge_pulse;
    logic comparator_rise;

    // Source pick; unused codes read low.
    function automatic logic pick_source(input logic [3:0] sel, input logic [1:0] pins,
                                         input logic cap_one, input logic cap_two);
        logic level;
        level = 1'b0;
        case (sel)
            ctu_pkg::SRC_EDGE_PIN_ONE: level = pins[0];
            ctu_pkg::SRC_EDGE_PIN_TWO: level = pins[1];
            ctu_pkg::SRC_CAPTURE_ONE:  level = cap_one;   // [R16]
            ctu_pkg::SRC_CAPTURE_TWO:  level = cap_two;   // [R16]
            default:                   level = 1'b0;
        endcase
        return level;
    endfunction

    // Selected levels that feed the two edge detectors.
    wire first_edge_level  = pick_source(first_edge_source_sel, pin_sync,
                                         capture_one_trigger_i, capture_two_trigger_i);   // [R6]
    wire second_edge_level = pick_source(second_edge_source_sel, pin_sync,
                                         capture_one_trigger_i, capture_two_trigger_i);   // [R6]

    // Pins and comparator cross into the clock domain.
    ctu_sync2 #(
        .WIDTH (3)
    ) u_pin_sync (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   ({comparator_out_i, edge_pin_two_i, edge_pin_one_i}),
        .sync_o    ({comparator_sync, pin_sync})
    );

    // First edge input with its own polarity.
    ctu_edge_detect u_first_edge (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .level_i   (first_edge_level),
        .rising_i  (first_edge_polarity),    // [R7]
        .edge_o    (first_edge_pulse)
    );

    // Second edge input with its own polarity.
    ctu_edge_detect u_second_edge (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .level_i   (second_edge_level),
        .rising_i  (second_edge_polarity),   // [R7]
        .edge_o    (second_edge_pulse)
    );

    // Comparator trips on its rise.
    ctu_edge_detect u_comparator_edge (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .level_i   (comparator_sync),
        .rising_i  (1'b1),
        .edge_o    (comparator_rise)
    );

    // Edges count only while the unit is on and both inputs are armed.
    wire edges_live = unit_enable & edges_armed;   // [R12] [R14]

    // A qualified first edge.
    wire first_edge_event = edges_live & first_edge_pulse;   // [R20]

    // With ordering, an early second edge is dropped.
    wire second_edge_event = edges_live & second_edge_pulse
                           & (~edge_order_enable | first_edge_seen);   // [R3]

    // In delay mode the comparator ends the pulse.
    wire pulse_end_event = unit_enable & delay_mode_sel & comparator_rise
                         & first_edge_seen & ~second_edge_seen;   // [R17]

    // Source state as it will be after this edge.
    logic source_on_next;
    assign source_on_next = unit_enable & next_first_edge_seen & ~next_second_edge_seen
                          & (current_range_sel != ctu_pkg::RANGE_OFF);   // [R20] [R18]

    // Source turning off is the interrupt event.
    wire source_off_event = current_on_o & ~source_on_next;   // [R1]

    // First status: a hardware set beats a software clear.
    // A software one starts the source like an edge.
    always_comb
    begin
        next_first_edge_seen = first_edge_seen;
        if (wr_first)
            next_first_edge_seen = wdata_i[ctu_pkg::BIT_FIRST_SEEN];   // [R15]
        if (first_edge_event)
            next_first_edge_seen = 1'b1;   // [R20]
    end

    // Second status: set by the second edge or comparator.
    // One write clearing both avoids a restart.
    always_comb
    begin
        next_second_edge_seen = second_edge_seen;
        if (wr_first)
            next_second_edge_seen = wdata_i[ctu_pkg::BIT_SECOND_SEEN];   // [R13]
        if (second_edge_event || pulse_end_event)
            next_second_edge_seen = 1'b1;   // [R20]
    end

    // Interrupt flag; the hardware set wins.
    always_comb
    begin
        next_peripheral_flag = peripheral_flag;
        if (wr_flag)
            next_peripheral_flag = wdata_i[ctu_pkg::BIT_UNIT_IRQ];
        if (source_off_event)
            next_peripheral_flag = 1'b1;   // [R1]
    end

    // Main control register; zero reset means measurement,
    // no ordering, no trigger and the unit off.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            main_control_reg <= ctu_pkg::RST_MAIN_CONTROL;   // [R8] [R9] [R10]
        else if (wr_main)
            main_control_reg <= wdata_i;
    end

    // Current range and trim register.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            current_config_reg <= ctu_pkg::RST_CURRENT_CFG;
        else if (wr_current)
            current_config_reg <= wdata_i;   // [R5]
    end

    // Edge configuration; polarity resets falling.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            first_edge_config_reg  <= ctu_pkg::RST_EDGE_CFG[6:2];   // [R7]
            second_edge_config_reg <= ctu_pkg::RST_EDGE_CFG[6:2];   // [R7]
        end
        else
        begin
            if (wr_first)
                first_edge_config_reg <= wdata_i[6:2];
            if (wr_second)
                second_edge_config_reg <= wdata_i[6:2];
        end
    end

    // Status bits and interrupt bits.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            first_edge_seen   <= ctu_pkg::RST_BIT;
            second_edge_seen  <= ctu_pkg::RST_BIT;
            peripheral_flag   <= ctu_pkg::RST_BIT;
            peripheral_enable <= ctu_pkg::RST_BIT;
        end
        else
        begin
            first_edge_seen  <= next_first_edge_seen;
            second_edge_seen <= next_second_edge_seen;
            peripheral_flag  <= next_peripheral_flag;
            if (wr_enable)
                peripheral_enable <= wdata_i[ctu_pkg::BIT_UNIT_IRQ];
        end
    end

    // Analog outputs; off while the unit is disabled.
    // Discharge stays with software even then,
    // since setup drains before enabling.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            current_on_o        <= 1'b0;
            discharge_o         <= 1'b0;
            comparator_ref_en_o <= 1'b0;
            pulse_o             <= 1'b0;
        end
        else
        begin
            current_on_o        <= source_on_next;                           // [R20]
            discharge_o         <= discharge_enable;                         // [R11]
            comparator_ref_en_o <= unit_enable & delay_mode_sel;             // [R17]
            pulse_o             <= delay_mode_sel & source_on_next;          // [R9]
        end
    end

    // Range and trim go straight out of their register.
    assign current_range_o = current_range_sel;   // [R18]
    assign current_trim_o  = current_trim;        // [R5]

    // Conversion start and interrupt request, both registered.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            adc_start_o <= 1'b0;
            irq_o       <= 1'b0;
        end
        else
        begin
            adc_start_o <= conversion_trigger_enable & second_edge_event;   // [R10]
            irq_o       <= next_peripheral_flag & peripheral_enable;        // [R2]
        end
    end

    // Read views; both status bits show
    // which edges have been seen.
    wire [7:0] rd_main    = main_control_reg;
    wire [7:0] rd_current = current_config_reg;
    wire [7:0] rd_second  = {1'b0, second_edge_config_reg, 2'b00};
    wire [7:0] rd_first   = {1'b0, first_edge_config_reg, second_edge_seen, first_edge_seen};   // [R4]
    wire [7:0] rd_flag    = {4'h0, peripheral_flag, 3'h0};
    wire [7:0] rd_enable  = {4'h0, peripheral_enable, 3'h0};
    wire [7:0] rd_live    = {6'h00, pulse_o, current_on_o};

    // Read multiplexer; unmapped addresses read zero.
    wire [7:0] rd_value =
        (addr_i == ctu_pkg::OFF_MAIN_CONTROL) ? rd_main    :
        (addr_i == ctu_pkg::OFF_CURRENT_CFG)  ? rd_current :
        (addr_i == ctu_pkg::OFF_SECOND_EDGE)  ? rd_second  :
        (addr_i == ctu_pkg::OFF_FIRST_EDGE)   ? rd_first   :
        (addr_i == ctu_pkg::OFF_FLAG_REG)     ? rd_flag    :
        (addr_i == ctu_pkg::OFF_ENABLE_REG)   ? rd_enable  :
        (addr_i == ctu_pkg::OFF_LIVE_STATUS)  ? rd_live    : 8'h00;

    // Read data stand one cycle, else zero.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rd_value;
        else
            rdata_o <= 8'h00;
    end

endmodule

// ---- verilog/ctu_edge_detect.sv ----
// Edge detector with a selectable polarity, one per edge input.
// Assumes its level input is already in the clock domain.
`timescale 1ns/1ns
module ctu_edge_detect (
    // Clock and reset.
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    // Level to watch and the wanted direction.
    input  wire logic level_i,
    input  wire logic rising_i,
    // One-cycle pulse on a transition in the wanted direction.
    output logic      edge_o
);

    logic level_prev;   // Level seen one clock earlier.

    // Resets low; a high level at release reads as a rise.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            level_prev <= 1'b0;
        else
            level_prev <= level_i;
    end

    // Polarity one picks low-to-high, zero picks high-to-low.
    assign edge_o = rising_i ? (level_i & ~level_prev) : (~level_i & level_prev);

endmodule

// ---- verilog/ctu_sync2.sv ----
// Two-stage synchroniser for levels that arrive from outside the clock domain.
// Assumes the input is a level held for at least two clock periods.
`timescale 1ns/1ns
module ctu_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    // Asynchronous level in, synchronised level out.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage_one;   // First stage, read only by the second.

    // Only the second stage reads the first.
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            stage_one <= '0;
            sync_o    <= '0;
        end
        else
        begin
            stage_one <= async_i;
            sync_o    <= stage_one;
        end
    end

endmodule
